/* core/call_stack_ptr.sv */
`timescale 1ns/100ps
module call_stack_ptr
   import pcs_pkg::*;
#(
   parameter int WIDTH = SP_W
) (
   input wire logic clk_sys_i, // Core clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire sp_op_e op_i, // Pointer operation
   input wire logic [WIDTH-1:0] load_val_i, // Value for a direct load
   output logic [WIDTH-1:0] sp_o // Current pointer
);

   logic [WIDTH-1:0] sp_q;
   logic [WIDTH-1:0] sp_d;

   // Plain modular arithmetic, no overflow or underflow detection
   always_comb begin
      unique case (op_i)
         SP_INC: sp_d = sp_q + WIDTH'(1);
         SP_DEC: sp_d = sp_q - WIDTH'(1);
         SP_LOAD: sp_d = load_val_i;
         default: sp_d = sp_q;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sp_q <= WIDTH'(RESET_SP);
      end else begin
         sp_q <= sp_d;
      end
   end

   assign sp_o = sp_q;

endmodule

/* core/pcs_pkg.sv */
package pcs_pkg;

   // Widths of the sequencing datapath
   localparam int PC_W = 14;
   localparam int PAGE_LO_W = 8;
   localparam int PAGE_HI_W = PC_W - PAGE_LO_W;
   localparam int SP_W = 8;
   localparam int BYTE_W = 8;
   localparam int LEN_W = 2;

   // Reset values
   localparam logic [PC_W-1:0] RESET_PC = 14'h0000;
   localparam logic [SP_W-1:0] RESET_SP = 8'h00;

   // Layout of the second stack byte: flags on top, upper counter bits below
   localparam int FLAG_C_POS = 7;
   localparam int FLAG_Z_POS = 6;
   localparam int HI_POS_LSB = 0;

   localparam logic [PAGE_HI_W-1:0] PAGE_STEP = 6'h01;

   // Decoder commands
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_STEP = 4'h1,
      CMD_PAGE_ADV = 4'h2,
      CMD_JUMP = 4'h3,
      CMD_CALL = 4'h4,
      CMD_SUB_RET = 4'h5,
      CMD_INT_RET = 4'h6,
      CMD_INT_ACK = 4'h7,
      CMD_LOAD_SP = 4'h8,
      CMD_INT_ENABLE = 4'h9,
      CMD_INT_DISABLE = 4'hA
   } cmd_e;

   typedef struct packed {
      cmd_e kind;
      logic [LEN_W-1:0] len;
      logic [PC_W-1:0] target;
      logic [BYTE_W-1:0] acc;
      logic carry;
      logic zero;
   } cmd_s;

   typedef struct packed {
      logic we;
      logic re;
      logic [SP_W-1:0] addr;
      logic [BYTE_W-1:0] wdata;
   } ram_req_s;

   typedef enum logic [1:0] {
      SP_HOLD = 2'h0,
      SP_INC = 2'h1,
      SP_DEC = 2'h2,
      SP_LOAD = 2'h3
   } sp_op_e;

endpackage

/* core/program_counter_stack_unit.sv */
`timescale 1ns/100ps
// Summary of operation
// - Keep a 14-bit counter, cleared by reset; first fetch at address zero.
// - Sequential steps advance only the low eight bits, wrapping inside the page.
// - Upper six counter bits increment only on the page advance instruction.
// - Call saves next address, interrupt acknowledge the current one, plus carry, zero as two bytes.
// - Acknowledge disables interrupts; write byte, increment, write byte, increment.
// - Reset sets the call stack pointer to zero; stack grows upward.
// - Load stack pointer instruction copies the accumulator into the pointer.
// - Interrupt return: decrement, restore second, decrement, restore first, then enable.
// - Carry and zero are restored only by the interrupt return instruction.
// - Subroutine return restores counter only, keeps flags, pointer drops by two.
// - Call pushes counter and flags, pointer rises by two.
// - No direct counter access; saved entries are plain RAM from address zero.
// - Reset starts at address zero and pushes nothing.
module program_counter_stack_unit
   import pcs_pkg::*;
#(
   parameter int PCW = PC_W
) (
   input wire logic clk_sys_i, // Core clock, 50 MHz
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire cmd_s cmd_i, // Decoder command
   input wire logic cmd_valid_i, // Command offered
   output logic cmd_ready_o, // Unit can take a command
   output logic [PCW-1:0] pc_o, // Fetch address
   output logic int_enable_o, // Global interrupt enable
   output logic flags_restore_o, // Pulse: load carry and zero
   output logic carry_o, // Restored carry
   output logic zero_o, // Restored zero
   output logic [SP_W-1:0] sp_o, // Call stack pointer
   output ram_req_s ram_req_o, // Stack RAM request
   input wire logic [BYTE_W-1:0] ram_rdata_i // Stack RAM read data
);

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PUSH2 = 5'h02,
      ST_POP2 = 5'h04,
      ST_POP_W1 = 5'h08,
      ST_POP_W2 = 5'h10
   } state_e;

   state_e state_q;
   state_e state_d;

   logic [PCW-1:0] pc_q;
   logic int_enable_q;
   logic flags_restore_q;
   logic carry_q;
   logic zero_q;
   ram_req_s ram_req_q;
   logic [BYTE_W-1:0] push_hi_q;
   logic [PCW-1:0] push_target_q;
   logic pop_is_int_q;
   logic [BYTE_W-1:0] pop_hi_q;
   sp_op_e sp_op;
   logic [SP_W-1:0] sp;
   logic take;
   logic take_push;
   logic take_pop;
   logic restore_int;
   logic [PCW-1:0] next_seq;
   logic [PCW-1:0] saved_pc;
   logic [PCW-1:0] popped_pc;

   // Advance the low byte by the instruction length, leaving the page bits alone
   function automatic logic [PCW-1:0] step_in_page(input logic [PCW-1:0] pc,
                                                   input logic [LEN_W-1:0] len);
      logic [PAGE_LO_W-1:0] lo;
      lo = pc[PAGE_LO_W-1:0] + PAGE_LO_W'(len);
      step_in_page = {pc[PCW-1:PAGE_LO_W], lo};
   endfunction

   // Second stack byte: flags above the upper counter bits
   function automatic logic [BYTE_W-1:0] pack_hi(input logic [PCW-1:0] pc,
                                                input logic c,
                                                input logic z);
      logic [BYTE_W-1:0] b;
      b = '0;
      b[HI_POS_LSB +: PAGE_HI_W] = pc[PCW-1:PAGE_LO_W];
      b[FLAG_C_POS] = c;
      b[FLAG_Z_POS] = z;
      pack_hi = b;
   endfunction

   // Commands that write a two-byte entry
   function automatic logic is_push(input cmd_e kind);
      is_push = (kind == CMD_CALL) || (kind == CMD_INT_ACK);
   endfunction

   // Commands that read a two-byte entry back
   function automatic logic is_pop(input cmd_e kind);
      is_pop = (kind == CMD_SUB_RET) || (kind == CMD_INT_RET);
   endfunction

   // Upper counter bits step to the next page, the low byte keeps its step
   function automatic logic [PCW-1:0] page_advance(input logic [PCW-1:0] pc);
      page_advance = {pc[PCW-1:PAGE_LO_W] + PAGE_STEP, pc[PAGE_LO_W-1:0]};
   endfunction

   assign take = cmd_valid_i && (state_q == ST_IDLE);
   assign take_push = take && is_push(cmd_i.kind);
   assign take_pop = take && is_pop(cmd_i.kind);
   // Last cycle of an interrupt return: counter, flags and enable come back together
   assign restore_int = (state_q == ST_POP_W2) && pop_is_int_q;
   assign next_seq = step_in_page(pc_q, cmd_i.len);
   // Interrupt entry saves the counter as is; a call saves the instruction after it
   assign saved_pc = (cmd_i.kind == CMD_INT_ACK) ? pc_q : next_seq;
   // Return address: upper bits from the first read, low byte straight from RAM
   assign popped_pc = {pop_hi_q[HI_POS_LSB +: PAGE_HI_W], ram_rdata_i};

   // Sequencer for the two-byte stack transfers
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (take) begin
               unique case (cmd_i.kind)
                  CMD_CALL, CMD_INT_ACK: state_d = ST_PUSH2;
                  CMD_SUB_RET, CMD_INT_RET: state_d = ST_POP2;
                  default: state_d = ST_IDLE;
               endcase
            end
         end
         ST_PUSH2: state_d = ST_IDLE;
         ST_POP2: state_d = ST_POP_W1;
         ST_POP_W1: state_d = ST_POP_W2;
         ST_POP_W2: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // Reset lands in idle with nothing pushed
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Pointer moves once per stack byte
   always_comb begin
      sp_op = SP_HOLD;
      unique case (state_q)
         ST_IDLE: begin
            if (take) begin
               unique case (cmd_i.kind)
                  CMD_CALL, CMD_INT_ACK: sp_op = SP_INC;
                  CMD_SUB_RET, CMD_INT_RET: sp_op = SP_DEC;
                  CMD_LOAD_SP: sp_op = SP_LOAD;
                  default: sp_op = SP_HOLD;
               endcase
            end
         end
         ST_PUSH2: sp_op = SP_INC;
         ST_POP2: sp_op = SP_DEC;
         default: sp_op = SP_HOLD;
      endcase
   end

   call_stack_ptr #(
      .WIDTH(SP_W)
   ) call_stack_ptr_i (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .op_i(sp_op),
      .load_val_i(cmd_i.acc),
      .sp_o(sp)
   );

   // Stack RAM requests, one byte per cycle
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ram_req_q <= '0;
      end else begin
         ram_req_q <= '0;
         unique case (state_q)
            ST_IDLE: begin
               if (take_push) begin
                  ram_req_q.we <= 1'b1;
                  ram_req_q.addr <= sp;
                  ram_req_q.wdata <= saved_pc[PAGE_LO_W-1:0];
               end else if (take_pop) begin
                  ram_req_q.re <= 1'b1;
                  ram_req_q.addr <= sp - SP_W'(1);
               end
            end
            ST_PUSH2: begin
               ram_req_q.we <= 1'b1;
               ram_req_q.addr <= sp;
               ram_req_q.wdata <= push_hi_q;
            end
            ST_POP2: begin
               ram_req_q.re <= 1'b1;
               ram_req_q.addr <= sp - SP_W'(1);
            end
            default: ram_req_q <= '0;
         endcase
      end
   end

   // Second byte of the entry, written one cycle after the first
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         push_hi_q <= '0;
      end else if (take) begin
         push_hi_q <= pack_hi(saved_pc, cmd_i.carry, cmd_i.zero);
      end
   end

   // Call or vector address, loaded into the counter at the end of the second push cycle
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         push_target_q <= RESET_PC;
      end else if (take) begin
         push_target_q <= cmd_i.target;
      end
   end

   // Only an interrupt return brings back flags and the enable
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pop_is_int_q <= 1'b0;
      end else if (take) begin
         pop_is_int_q <= (cmd_i.kind == CMD_INT_RET);
      end
   end

   // Read data of the second byte arrives first
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pop_hi_q <= '0;
      end else if (state_q == ST_POP_W1) begin
         pop_hi_q <= ram_rdata_i;
      end
   end

   // Program counter: only sequencing logic can change it
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pc_q <= RESET_PC;
      end else if (take) begin
         unique case (cmd_i.kind)
            CMD_STEP: pc_q <= next_seq;
            CMD_PAGE_ADV: pc_q <= page_advance(next_seq);
            CMD_JUMP: pc_q <= cmd_i.target;
            CMD_LOAD_SP, CMD_INT_ENABLE, CMD_INT_DISABLE: pc_q <= next_seq;
            default: pc_q <= pc_q;
         endcase
      end else if (state_q == ST_PUSH2) begin
         pc_q <= push_target_q;
      end else if (state_q == ST_POP_W2) begin
         pc_q <= popped_pc;
      end
   end

   // Global interrupt enable
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         int_enable_q <= 1'b0;
      end else if (take && cmd_i.kind == CMD_INT_ACK) begin
         int_enable_q <= 1'b0;
      end else if (take && cmd_i.kind == CMD_INT_DISABLE) begin
         int_enable_q <= 1'b0;
      end else if (take && cmd_i.kind == CMD_INT_ENABLE) begin
         int_enable_q <= 1'b1;
      end else if (restore_int) begin
         int_enable_q <= 1'b1;
      end
   end

   // One-cycle pulse that tells the core to load carry and zero
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         flags_restore_q <= 1'b0;
      end else begin
         flags_restore_q <= restore_int;
      end
   end

   // Flag restore happens only at the end of an interrupt return
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         carry_q <= 1'b0;
         zero_q <= 1'b0;
      end else if (restore_int) begin
         carry_q <= pop_hi_q[FLAG_C_POS];
         zero_q <= pop_hi_q[FLAG_Z_POS];
      end
   end

   // No firmware path to the counter; the stack is only visible as RAM
   assign pc_o = pc_q;
   assign cmd_ready_o = (state_q == ST_IDLE);
   assign int_enable_o = int_enable_q;
   assign flags_restore_o = flags_restore_q;
   assign carry_o = carry_q;
   assign zero_o = zero_q;
   assign sp_o = sp;
   assign ram_req_o = ram_req_q;

endmodule

/* tb/pcs_checker.sv */
`timescale 1ns/100ps
module pcs_checker
   import pcs_pkg::*;
(
   input wire logic clk_sys_i, // Core clock
   input wire logic rst_n_i, // Reset, active low
   input wire cmd_s cmd_i, // Command
   input wire logic cmd_valid_i, // Command offered
   input wire logic cmd_ready_o, // Unit ready
   input wire logic [PC_W-1:0] pc_o, // Counter
   input wire logic int_enable_o, // Interrupt enable
   input wire logic flags_restore_o, // Flag load pulse
   input wire logic carry_o, // Carry
   input wire logic zero_o, // Zero
   input wire logic [SP_W-1:0] sp_o, // Pointer
   input wire ram_req_s ram_req_o // RAM request
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   logic tk;
   cmd_e k;
   assign tk = cmd_valid_i && cmd_ready_o;
   assign k = cmd_i.kind;
   property p_reset;
      disable iff (1'b0)
      !rst_n_i |=> pc_o == RESET_PC && sp_o == RESET_SP && !int_enable_o && !ram_req_o.we;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_step;
      tk && k == CMD_STEP |=>
         pc_o == {$past(pc_o[13:8]), 8'($past(pc_o[7:0]) + $past(cmd_i.len))};
   endproperty
   a_step: assert property (p_step) else $error("step left page");
   property p_page;
      tk && k == CMD_PAGE_ADV |=> pc_o[13:8] == $past(pc_o[13:8]) + PAGE_STEP;
   endproperty
   a_page: assert property (p_page) else $error("page advance wrong");
   property p_push;
      tk && (k == CMD_CALL || k == CMD_INT_ACK) |=> ram_req_o.we && ram_req_o.addr == $past(sp_o)
         ##1 ram_req_o.we && ram_req_o.addr == $past(sp_o, 2) + 8'h01
         && sp_o == $past(sp_o, 2) + 8'h02 ##1 ($past(tk) || !ram_req_o.we);
   endproperty
   a_push: assert property (p_push) else $error("push sequence wrong");
   property p_ack;
      tk && k == CMD_INT_ACK |=> !int_enable_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack kept interrupts");
   property p_pull;
      tk && (k == CMD_SUB_RET || k == CMD_INT_RET) |=>
         ram_req_o.re && ram_req_o.addr == $past(sp_o) - 8'h01 ##1 ram_req_o.re
         && ram_req_o.addr == sp_o && sp_o == $past(sp_o, 2) - 8'h02;
   endproperty
   a_pull: assert property (p_pull) else $error("pop sequence wrong");
   property p_iret;
      tk && k == CMD_INT_RET |=> $stable(int_enable_o) [*3] ##1 int_enable_o && flags_restore_o;
   endproperty
   a_iret: assert property (p_iret) else $error("enable too early");
   property p_flags;
      $past(rst_n_i) && !flags_restore_o |-> $stable(carry_o) && $stable(zero_o);
   endproperty
   a_flags: assert property (p_flags) else $error("flags moved");
   property p_load;
      tk && k == CMD_LOAD_SP |=> sp_o == $past(cmd_i.acc);
   endproperty
   a_load: assert property (p_load) else $error("pointer load wrong");
   c_iret: cover property (tk && k == CMD_INT_RET);
   c_wrap: cover property (tk && k == CMD_CALL && sp_o == 8'hFF);
   c_page: cover property (tk && k == CMD_PAGE_ADV);
endmodule

/* tb/stack_ram_model.sv */
`timescale 1ns/100ps
module stack_ram_model
   import pcs_pkg::*;
(
   input wire logic clk_sys_i, // Core clock
   input wire ram_req_s req_i, // Request from the unit
   output logic [BYTE_W-1:0] rdata_o // Read data, one cycle late
);
   logic [BYTE_W-1:0] mem [256] = '{default: 8'h00};
   initial rdata_o = 8'h00;
   // Read data is good for one cycle only, then it toggles
   always @(posedge clk_sys_i) begin
      if (req_i.we) mem[req_i.addr] <= req_i.wdata;
      rdata_o <= req_i.re ? mem[req_i.addr] : ~rdata_o;
   end
endmodule

/* tb/test_program_counter_stack_unit.sv */
`timescale 1ns/100ps
module test_program_counter_stack_unit;
   import pcs_pkg::*;
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [SP_W-1:0] sp;
      logic ie, c, z, fr;
   } note_s;
   logic clk_sys_i = 0, rst_n_i = 0, cmd_valid_i = 0, took = 0, opn = 0;
   logic cmd_ready_o, int_enable_o, flags_restore_o, carry_o, zero_o;
   logic [PC_W-1:0] pc_o;
   logic [SP_W-1:0] sp_o;
   logic [BYTE_W-1:0] ram_rdata_i;
   cmd_s cmd_i = '0;
   ram_req_s ram_req_o;
   note_s m, q[$];
   logic [7:0] stk [256] = '{default: 8'h00};
   int fail_count = 0, n_compared = 0, seed = 27827;
   program_counter_stack_unit program_counter_stack_unit_i (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
      .pc_o(pc_o), .int_enable_o(int_enable_o), .flags_restore_o(flags_restore_o),
      .carry_o(carry_o), .zero_o(zero_o), .sp_o(sp_o), .ram_req_o(ram_req_o),
      .ram_rdata_i(ram_rdata_i));
   stack_ram_model stack_ram_model_i (.clk_sys_i(clk_sys_i), .req_i(ram_req_o),
      .rdata_o(ram_rdata_i));
   always #10 clk_sys_i = ~clk_sys_i;
   function automatic note_s seen();
      return {pc_o, sp_o, int_enable_o, carry_o, zero_o, flags_restore_o};
   endfunction
   task automatic chk(logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_sys_i) took <= rst_n_i && cmd_valid_i && cmd_ready_o;
   // Each finished command is compared with the oldest note
   always @(negedge clk_sys_i) begin
      if (took) opn = 1;
      if (opn && cmd_ready_o && q.size() > 0) begin
         opn = 0;
         chk(32'(seen()), 32'(q.pop_front()));
      end
   end
   task automatic do_reset();
      rst_n_i = 0;
      cmd_valid_i = 0;
      q.delete();
      opn = 0;
      repeat (6) @(posedge clk_sys_i);
      #1;
      rst_n_i = 1;
      m = '0;
      q.delete();
      opn = 0;
      chk(32'(seen()), 32'(m));
   endtask
   task automatic idle();
      cmd_valid_i = 0;
      repeat (5) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic op(cmd_e k, logic [1:0] l = 0, logic [13:0] t = 0, logic [7:0] a = 0);
      logic cf, zf, r;
      logic [7:0] nl, s1;
      int w;
      cf = 1'($random(seed));
      zf = 1'($random(seed));
      cmd_i = '{k, l, t, a, cf, zf};
      cmd_valid_i = 1;
      w = 0;
      do begin
         r = cmd_ready_o;
         @(posedge clk_sys_i);
         #1;
         w++;
      end while (!r && w < 20);
      if (w >= 20) fail_count++;
      nl = m.pc[7:0] + 8'(l);
      s1 = m.sp + 8'h01;
      m.fr = 0;
      case (k)
         CMD_STEP, CMD_LOAD_SP, CMD_INT_ENABLE, CMD_INT_DISABLE: m.pc[7:0] = nl;
         CMD_PAGE_ADV: m.pc = {m.pc[13:8] + 6'h01, nl};
         CMD_JUMP: m.pc = t;
         CMD_CALL, CMD_INT_ACK: begin
            if (k == CMD_CALL) m.pc[7:0] = nl;
            else m.ie = 0;
            stk[m.sp] = m.pc[7:0];
            stk[s1] = {cf, zf, m.pc[13:8]};
            m.sp += 8'h02;
            m.pc = t;
         end
         CMD_SUB_RET, CMD_INT_RET: begin
            m.sp -= 8'h02;
            s1 = m.sp + 8'h01;
            m.pc = {stk[s1][5:0], stk[m.sp]};
            if (k == CMD_INT_RET) {m.c, m.z, m.ie, m.fr} = {stk[s1][7:6], 2'b11};
         end
         default: ;
      endcase
      if (k == CMD_LOAD_SP) m.sp = a;
      if (k == CMD_INT_ENABLE) m.ie = 1;
      if (k == CMD_INT_DISABLE) m.ie = 0;
      q.push_back(m);
   endtask
   initial begin
      #200us;
      fail_count++;
      summarize();
   end
   initial begin
      do_reset();
      $display("test reset done");
      op(CMD_JUMP, 0, 14'h12FD);
      repeat (4) op(CMD_STEP, 2'h3);
      op(CMD_PAGE_ADV, 2'h1);
      op(CMD_JUMP, 0, 14'h3FFF);
      op(CMD_PAGE_ADV, 2'h2);
      idle();
      $display("test paging done");
      op(CMD_INT_ENABLE);
      op(CMD_LOAD_SP, 2'h1, 0, 8'hFF);
      op(CMD_CALL, 2'h2, 14'h0200);
      op(CMD_INT_ACK, 0, 14'h0008);
      op(CMD_INT_RET);
      op(CMD_SUB_RET);
      idle();
      chk(32'(stack_ram_model_i.mem[8'hFF]), 32'(stk[8'hFF]));
      chk(32'(stack_ram_model_i.mem[8'h02]), 32'(stk[8'h02]));
      $display("test stack done");
      repeat (300) op(cmd_e'($unsigned($random(seed)) % 11), 2'($random(seed)),
         14'($random(seed)), 8'($random(seed)));
      idle();
      $display("test random mix done");
      op(CMD_CALL, 2'h1, 14'h0100);
      do_reset();
      op(CMD_STEP, 2'h1);
      idle();
      $display("test reset in push done");
      summarize();
   end
endmodule
bind program_counter_stack_unit pcs_checker pcs_checker_i (.clk_sys_i(clk_sys_i),
   .rst_n_i(rst_n_i), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
   .pc_o(pc_o), .int_enable_o(int_enable_o), .flags_restore_o(flags_restore_o),
   .carry_o(carry_o), .zero_o(zero_o), .sp_o(sp_o), .ram_req_o(ram_req_o));
